// ---- logic/lcd_seg_driver.sv ----
// Contract
// RQ1: on latch, copy the whole shift register into the display data register.
// RQ2: host presents bits on serial input, device samples them with the shift clock.
// RQ3: last shift register stage drives the serial output for cascading.
// RQ4: all enable inputs are active low.
// RQ5: low segment group enable gates segments one to sixteen.
// RQ6: high segment group enable gates segments seventeen to forty.
// RQ7: each common output has its own enable.
// RQ8: oscillator enable switches the internal oscillator on or off.
// RQ9: internal oscillator appears on a dedicated output.
// RQ10: all divider timing derives from the single clock input.
// RQ11: divider gives clock input over 16,32,64,128,256,8192,16384,32768.
// RQ12: lcd drive clock comes from its own input pin.
// RQ13: blink timing comes from its own blink clock input.
// RQ14: blink enable makes the blink clock modulate displayed segments.
// RQ15: one bit shifts in on each rising shift clock edge.
// RQ16: transfer to the data register happens on the latch rising edge.
// RQ17: host sends segment forty first and segment one last.
// RQ18: an enabled common drives the inverse of the lcd drive clock.
// RQ19: set segment follows drive clock, cleared segment follows the common.
// RQ20: disabled segment group or common holds constant low.
// RQ21: reset clears shift and data registers.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/10ps
module lcd_seg_driver
    import lcd_seg_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // serial host link
    input wire logic serial_data_i,
    input wire logic shift_clock_i,
    input wire logic latch_strobe_i,
    output logic serial_out_o,
    // clocking pins
    input wire logic osc_enable_n_i,
    output logic osc_out_o,
    input wire logic clock_in_i,
    output logic [DIV_TAPS-1:0] div_tap_o,
    input wire logic lcd_drive_clock_i,
    input wire logic blink_clock_i,
    input wire logic blink_enable_n_i,
    // output enables
    input wire logic seg_group_low_enable_n_i,
    input wire logic seg_group_high_enable_n_i,
    input wire logic common_a_enable_n_i,
    input wire logic common_b_enable_n_i,
    // lcd outputs, bit 0 is the first segment
    output logic [SEG_COUNT-1:0] segment_out_o,
    output logic common_out_a_o,
    output logic common_out_b_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef struct packed {
        logic [SEG_COUNT-1:0] shift;
        logic [SEG_COUNT-1:0] data;
        logic [SEG_COUNT-1:0] seg;
        logic com_a;
        logic com_b;
        logic [OSC_CNT_W-1:0] osc_cnt;
        logic osc;
        logic display_off;
        logic [1:0] warm;
        logic ack;
        logic [31:0] rdata;
    } drv_state_t;

    localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(OSC_HALF_CYCLES - 1);
    localparam logic [1:0] SYNC_FILL = 2'(SYNC_FILL_CYCLES);

    drv_state_t st_q;
    drv_state_t st_d;
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] lvl;
    logic [PIN_COUNT-1:0] rise;
    logic lcd_drive_clock;
    logic blank;
    logic seg_low_on;
    logic seg_high_on;
    logic com_a_on;
    logic com_b_on;
    logic [7:0] word_adr;
    logic req;
    logic settled;
    logic dark;

    assign pins[P_CLOCK_IN] = clock_in_i; // RQ10
    assign pins[P_SHIFT_CLOCK] = shift_clock_i;
    assign pins[P_LATCH] = latch_strobe_i;
    assign pins[P_SERIAL_IN] = serial_data_i;
    assign pins[P_LCD_CLOCK] = lcd_drive_clock_i; // RQ12
    assign pins[P_BLINK_CLOCK] = blink_clock_i; // RQ13
    assign pins[P_OSC_EN_N] = osc_enable_n_i;
    assign pins[P_BLINK_EN_N] = blink_enable_n_i;
    assign pins[P_SEG_LOW_EN_N] = seg_group_low_enable_n_i;
    assign pins[P_SEG_HIGH_EN_N] = seg_group_high_enable_n_i;
    assign pins[P_COM_A_EN_N] = common_a_enable_n_i;
    assign pins[P_COM_B_EN_N] = common_b_enable_n_i;

    pin_sync #(
        .W(PIN_COUNT)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .pin_i(pins),
        .level_o(lvl),
        .rise_o(rise)
    );

    clk_divider u_clk_divider (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .tick_i(rise[P_CLOCK_IN]),
        .tap_o(div_tap_o)
    );

    assign lcd_drive_clock = lvl[P_LCD_CLOCK];
    // a low level enables each function
    assign seg_low_on = !lvl[P_SEG_LOW_EN_N]; // RQ4
    assign seg_high_on = !lvl[P_SEG_HIGH_EN_N]; // RQ4
    assign com_a_on = !lvl[P_COM_A_EN_N]; // RQ4
    assign com_b_on = !lvl[P_COM_B_EN_N]; // RQ4
    // blink hides the data while the blink clock is high
    assign blank = !lvl[P_BLINK_EN_N] && lvl[P_BLINK_CLOCK]; // RQ14 RQ4
    assign word_adr = {wb_adr_i[7:2], 2'b00};
    assign req = wb_cyc_i && wb_stb_i && !st_q.ack;
    // outputs stay dark until the synchronisers hold real pin levels
    assign settled = st_q.warm == SYNC_FILL; // RQ20
    assign dark = st_q.display_off || !settled;

    always_comb begin
        st_d = st_q;
        if (ce_i) begin
            // saturates once the pin levels are real
            if (!settled) begin
                st_d.warm = st_q.warm + 2'd1;
            end
            // latch sees the shift register before this cycle's shift
            if (rise[P_LATCH]) begin
                st_d.data = st_q.shift; // RQ1 RQ16
            end
            if (rise[P_SHIFT_CLOCK]) begin
                st_d.shift = {st_q.shift[SEG_COUNT-2:0], lvl[P_SERIAL_IN]}; // RQ15 RQ2 RQ17
            end

            for (int i = 0; i < SEG_COUNT; i++) begin
                if (dark || !(i < LOW_GROUP_SIZE ? seg_low_on : seg_high_on)) begin
                    st_d.seg[i] = 1'b0; // RQ20 RQ5 RQ6
                end else if (st_q.data[i] && !blank) begin
                    st_d.seg[i] = lcd_drive_clock; // RQ19
                end else begin
                    st_d.seg[i] = !lcd_drive_clock; // RQ19 RQ14
                end
            end
            st_d.com_a = com_a_on && !dark && !lcd_drive_clock; // RQ18 RQ7 RQ20
            st_d.com_b = com_b_on && !dark && !lcd_drive_clock; // RQ18 RQ7 RQ20

            if (lvl[P_OSC_EN_N]) begin
                st_d.osc = 1'b0; // RQ8
                st_d.osc_cnt = '0;
            end else if (st_q.osc_cnt == OSC_LAST) begin
                st_d.osc = !st_q.osc; // RQ8 RQ9
                st_d.osc_cnt = '0;
            end else begin
                st_d.osc_cnt = st_q.osc_cnt + 1'b1;
            end

            // wishbone: answer one cycle after the request, drop ack the next
            st_d.ack = req;
            if (req) begin
                st_d.rdata = 32'h0000_0000;
                case (word_adr)
                    REG_CTRL: begin
                        st_d.rdata[CTRL_DISPLAY_OFF] = st_q.display_off;
                    end
                    REG_STATUS: begin
                        st_d.rdata[11:0] = {lvl[11:6], st_q.osc, blank, 4'h0};
                    end
                    REG_DATA_LO: begin
                        st_d.rdata = st_q.data[31:0];
                    end
                    REG_DATA_HI: begin
                        st_d.rdata[SEG_COUNT-33:0] = st_q.data[SEG_COUNT-1:32];
                    end
                    REG_SHIFT_LO: begin
                        st_d.rdata = st_q.shift[31:0];
                    end
                    REG_SHIFT_HI: begin
                        st_d.rdata[SEG_COUNT-33:0] = st_q.shift[SEG_COUNT-1:32];
                    end
                    default: begin
                        st_d.rdata = 32'h0000_0000;
                    end
                endcase
                if (wb_we_i && wb_sel_i[0] && word_adr == REG_CTRL) begin
                    st_d.display_off = wb_dat_i[CTRL_DISPLAY_OFF];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
            st_q.shift <= DATA_RESET; // RQ21
            st_q.data <= DATA_RESET; // RQ21
            st_q.display_off <= CTRL_DISPLAY_OFF_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign serial_out_o = st_q.shift[SEG_COUNT-1]; // RQ3
    assign osc_out_o = st_q.osc; // RQ9
    assign segment_out_o = st_q.seg;
    assign common_out_a_o = st_q.com_a;
    assign common_out_b_o = st_q.com_b;
    assign wb_dat_o = st_q.rdata;
    assign wb_ack_o = st_q.ack;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    // serial path
    a_latch_copy: assert property (ce_i && rise[P_LATCH] |=> st_q.data == $past(st_q.shift)) // RQ1
        else $error("display data did not take the shift register on latch");
    a_shift_in: assert property (ce_i && rise[P_SHIFT_CLOCK] // RQ15
        |=> st_q.shift == {$past(st_q.shift[SEG_COUNT-2:0]), $past(lvl[P_SERIAL_IN])})
        else $error("shift register did not take one bit on shift clock edge");
    a_shift_hold: assert property (ce_i && !rise[P_SHIFT_CLOCK] |=> $stable(st_q.shift)) // RQ15
        else $error("shift register moved without a shift clock edge");
    a_serial_cascade: assert property (ce_i && rise[P_SHIFT_CLOCK] // RQ3
        |=> serial_out_o == $past(st_q.shift[SEG_COUNT-2]))
        else $error("serial output is not the last shift stage");
    a_data_hold: assert property (ce_i && !rise[P_LATCH] |=> $stable(st_q.data)) // RQ16
        else $error("display data changed without a latch edge");

    // lcd outputs
    a_low_group_off: assert property (ce_i && lvl[P_SEG_LOW_EN_N] // RQ5
        |=> segment_out_o[LOW_GROUP_SIZE-1:0] == '0)
        else $error("disabled low segment group not low");
    a_high_group_off: assert property (ce_i && lvl[P_SEG_HIGH_EN_N] // RQ6
        |=> segment_out_o[SEG_COUNT-1:LOW_GROUP_SIZE] == '0)
        else $error("disabled high segment group not low");
    a_dark_outputs: assert property (ce_i && dark // RQ20
        |=> segment_out_o == '0 && !common_out_a_o && !common_out_b_o)
        else $error("outputs not low while the display is dark");
    a_common_a_drive: assert property (ce_i && com_a_on && !dark // RQ18
        |=> common_out_a_o == !$past(lcd_drive_clock))
        else $error("common a is not the inverted drive clock");
    a_common_b_drive: assert property (ce_i && com_b_on && !dark // RQ18
        |=> common_out_b_o == !$past(lcd_drive_clock))
        else $error("common b is not the inverted drive clock");
    a_common_a_off: assert property (ce_i && !com_a_on |=> !common_out_a_o) // RQ7
        else $error("disabled common a not low");
    a_common_b_off: assert property (ce_i && !com_b_on |=> !common_out_b_o) // RQ7
        else $error("disabled common b not low");
    a_seg_phase: assert property (ce_i && seg_low_on && !dark && !blank // RQ19
        |=> segment_out_o[0] == ($past(st_q.data[0]) ? $past(lcd_drive_clock) : !$past(lcd_drive_clock)))
        else $error("segment phase does not match its data bit");
    a_seg_high_phase: assert property (ce_i && seg_high_on && !dark && !blank // RQ19
        |=> segment_out_o[SEG_COUNT-1]
            == ($past(st_q.data[SEG_COUNT-1]) ? $past(lcd_drive_clock) : !$past(lcd_drive_clock)))
        else $error("last segment phase does not match its data bit");
    a_blink_hide: assert property (ce_i && blank && seg_high_on && !dark // RQ14
        |=> segment_out_o[SEG_COUNT-1] == !$past(lcd_drive_clock))
        else $error("blinked segment not in phase with common");

    // clocking and bus
    a_osc_stopped: assert property (ce_i && lvl[P_OSC_EN_N] |=> !osc_out_o) // RQ8
        else $error("oscillator output runs while disabled");
    a_osc_half_period: assert property (ce_i && !lvl[P_OSC_EN_N] // RQ9
        && st_q.osc_cnt != OSC_LAST |=> $stable(osc_out_o))
        else $error("oscillator toggled before its half period ended");
    a_tap_hold: assert property (ce_i && !rise[P_CLOCK_IN] |=> $stable(div_tap_o)) // RQ11
        else $error("divider taps moved without a clock input edge");
    a_ack_answer: assert property (ce_i && req |=> wb_ack_o)
        else $error("wishbone request not answered in the next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack held longer than one cycle");
    a_state_frozen: assert property (!ce_i |=> $stable(st_q))
        else $error("state changed while the clock enable was low");

    c_latch_event: cover property (ce_i && rise[P_LATCH]);
    c_blink_active: cover property (ce_i && blank && seg_low_on);
    c_ctrl_write: cover property (req && wb_we_i && word_adr == REG_CTRL);
    c_osc_toggle: cover property (ce_i && !lvl[P_OSC_EN_N] ##1 $changed(osc_out_o));
    c_clock_frozen: cover property (!ce_i ##1 !ce_i);
endmodule : lcd_seg_driver

// ---- logic/lcd_seg_pkg.sv ----
package lcd_seg_pkg;

    // display geometry
    localparam int SEG_COUNT = 40;
    localparam int LOW_GROUP_SIZE = 16;
    localparam logic [39:0] DATA_RESET = 40'h00_0000_0000;

    // system clock and internal oscillator
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int OSC_HZ = 32_000;
    localparam int OSC_HALF_CYCLES = CLK_HZ / (2 * OSC_HZ);
    localparam int OSC_CNT_W = 12;
    // edges until the pin synchroniser shows real pin levels after reset
    localparam int SYNC_FILL_CYCLES = 2;

    // divider: 15-bit counter, tap k toggles with period 2**(bit+1) input edges
    localparam int DIV_WIDTH = 15;
    localparam int DIV_TAPS = 8;
    localparam int DIV_TAP_BIT [DIV_TAPS] = '{3, 4, 5, 6, 7, 12, 13, 14};

    // positions of the pins inside the synchroniser vector
    localparam int PIN_COUNT = 12;
    localparam int P_CLOCK_IN = 0;
    localparam int P_SHIFT_CLOCK = 1;
    localparam int P_LATCH = 2;
    localparam int P_SERIAL_IN = 3;
    localparam int P_LCD_CLOCK = 4;
    localparam int P_BLINK_CLOCK = 5;
    localparam int P_OSC_EN_N = 6;
    localparam int P_BLINK_EN_N = 7;
    localparam int P_SEG_LOW_EN_N = 8;
    localparam int P_SEG_HIGH_EN_N = 9;
    localparam int P_COM_A_EN_N = 10;
    localparam int P_COM_B_EN_N = 11;

    // wishbone register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA_LO = 8'h08;
    localparam logic [7:0] REG_DATA_HI = 8'h0c;
    localparam logic [7:0] REG_SHIFT_LO = 8'h10;
    localparam logic [7:0] REG_SHIFT_HI = 8'h14;
    localparam int CTRL_DISPLAY_OFF = 0;
    localparam logic CTRL_DISPLAY_OFF_RESET = 1'b0;

endpackage : lcd_seg_pkg

// ---- logic/pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // asynchronous pins
    input wire logic [W-1:0] pin_i,
    // synchronised level and rising-edge pulse
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
        logic [W-1:0] prev;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (ce_i) begin
            st_d.meta = pin_i;
            st_d.stable = st_q.meta;
            st_d.prev = st_q.stable;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.stable;
    assign rise_o = st_q.stable & ~st_q.prev;
endmodule : pin_sync

// ---- logic/clk_divider.sv ----
`timescale 1ns/10ps
module clk_divider
    import lcd_seg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // one pulse per rising edge of the clock input
    input wire logic tick_i,
    // divided outputs
    output logic [DIV_TAPS-1:0] tap_o
);
    typedef struct packed {
        logic [DIV_WIDTH-1:0] count;
    } div_state_t;

    div_state_t st_q;
    div_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (ce_i && tick_i) begin
            st_d.count = st_q.count + 1'b1; // RQ10
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        for (int k = 0; k < DIV_TAPS; k++) begin
            tap_o[k] = st_q.count[DIV_TAP_BIT[k]]; // RQ11
        end
    end
endmodule : clk_divider

// ---- bench/host_link.sv ----
`timescale 1ns/10ps
module host_link (
    // clock
    input wire logic clk_sys_i,
    // serial pins towards the device
    output logic serial_data_o,
    output logic shift_clock_o,
    output logic latch_strobe_o
);
    initial begin
        serial_data_o = 1'b0;
        shift_clock_o = 1'b0;
        latch_strobe_o = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : hold

    // bit set up before the rising shift edge and held well past it
    task automatic send_bit(input logic b);
        serial_data_o <= b;
        hold(4);
        shift_clock_o <= 1'b1;
        hold(4);
        shift_clock_o <= 1'b0;
        // hold time over: the line no longer shows the bit
        serial_data_o <= ~b;
        hold(4);
    endtask : send_bit

    task automatic latch();
        latch_strobe_o <= 1'b1;
        hold(4);
        latch_strobe_o <= 1'b0;
        hold(4);
    endtask : latch
endmodule : host_link

// ---- bench/static_lcd_segment_driver_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module static_lcd_segment_driver_tb;
    import lcd_seg_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i, ce_i, serial_data_i, shift_clock_i, latch_strobe_i, serial_out_o;
    logic osc_enable_n_i, osc_out_o, clock_in_i, lcd_drive_clock_i, blink_clock_i;
    logic blink_enable_n_i, seg_group_low_enable_n_i, seg_group_high_enable_n_i;
    logic common_a_enable_n_i, common_b_enable_n_i, common_out_a_o, common_out_b_o;
    logic [DIV_TAPS-1:0] div_tap_o;
    logic [SEG_COUNT-1:0] segment_out_o;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [39:0] shift_m, data_m, w;
    int miscompares = 0;
    int checks_done = 0;
    int seed = 32'hb84e;
    int n, hi;

    always #2 clk_sys_i = ~clk_sys_i;

    lcd_seg_driver i_lcd_seg_driver (.clk_sys_i, .rst_b_i, .ce_i, .serial_data_i,
        .shift_clock_i, .latch_strobe_i, .serial_out_o, .osc_enable_n_i, .osc_out_o,
        .clock_in_i, .div_tap_o, .lcd_drive_clock_i, .blink_clock_i, .blink_enable_n_i,
        .seg_group_low_enable_n_i, .seg_group_high_enable_n_i, .common_a_enable_n_i,
        .common_b_enable_n_i, .segment_out_o, .common_out_a_o, .common_out_b_o,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);

    host_link i_host_link (.clk_sys_i, .serial_data_o(serial_data_i),
        .shift_clock_o(shift_clock_i), .latch_strobe_o(latch_strobe_i));

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            $display("[ERR] wb_ack expected 1 seen %b", wb_ack_o);
            final_report();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wb

    task automatic chk_regs();
        wb(1'b0, REG_SHIFT_LO, 32'h0);
        `CHK("shift_lo", shift_m[31:0], q)
        wb(1'b0, REG_SHIFT_HI, 32'h0);
        `CHK("shift_hi", {24'h0, shift_m[39:32]}, q)
        wb(1'b0, REG_DATA_LO, 32'h0);
        `CHK("data_lo", data_m[31:0], q)
        wb(1'b0, REG_DATA_HI, 32'h0);
        `CHK("data_hi", {24'h0, data_m[39:32]}, q)
    endtask : chk_regs

    // walk all output enable combinations at both drive clock levels
    task automatic check_pins(input bit blank);
        logic [39:0] e;
        for (int c = 0; c < 32; c++) begin
            {lcd_drive_clock_i, common_b_enable_n_i, common_a_enable_n_i,
                seg_group_high_enable_n_i, seg_group_low_enable_n_i} <= c[4:0];
            repeat (8) @(posedge clk_sys_i);
            e = '0;
            for (int i = 0; i < SEG_COUNT; i++)
                if (!((i < LOW_GROUP_SIZE) ? c[0] : c[1]))
                    e[i] = (data_m[i] && !blank) ? c[4] : !c[4];
            `CHK("segments", e, segment_out_o)
            `CHK("common_a", !c[2] & !c[4], common_out_a_o)
            `CHK("common_b", !c[3] & !c[4], common_out_b_o)
        end
    endtask : check_pins

    initial begin
        repeat (80000) @(posedge clk_sys_i);
        miscompares++;
        final_report();
    end

    initial begin
        rst_b_i = 1'b0;
        ce_i = 1'b1;
        {clock_in_i, lcd_drive_clock_i, blink_clock_i} = 3'h0;
        {blink_enable_n_i, osc_enable_n_i} = 2'h3;
        {seg_group_low_enable_n_i, seg_group_high_enable_n_i} = 2'h0;
        {common_a_enable_n_i, common_b_enable_n_i} = 2'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        shift_m = '0;
        data_m = '0;
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        chk_regs();
        w = 40'({$random(seed), $random(seed)});
        for (int i = 39; i >= 0; i--) begin
            i_host_link.send_bit(w[i]);
            shift_m = {shift_m[38:0], w[i]};
            `CHK("serial_out", shift_m[39], serial_out_o)
        end
        chk_regs();
        i_host_link.latch();
        data_m = shift_m;
        chk_regs();
        blink_clock_i <= 1'b1;
        check_pins(1'b0);
        blink_enable_n_i <= 1'b0;
        check_pins(1'b1);
        blink_clock_i <= 1'b0;
        check_pins(1'b0);
        i_host_link.send_bit(~w[39]);
        shift_m = {shift_m[38:0], ~w[39]};
        `CHK("serial_out", shift_m[39], serial_out_o)
        chk_regs();
        // everything enabled with the drive clock low, so only display_off can darken
        {lcd_drive_clock_i, common_b_enable_n_i, common_a_enable_n_i,
            seg_group_high_enable_n_i, seg_group_low_enable_n_i} <= 5'h0;
        wb(1'b1, REG_CTRL, 32'h1);
        repeat (8) @(posedge clk_sys_i);
        `CHK("off_outputs", 42'h0, {segment_out_o, common_out_a_o, common_out_b_o})
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl", 32'h1, q)
        wb(1'b1, REG_CTRL, 32'h0);
        repeat (8) @(posedge clk_sys_i);
        `CHK("on_segments", ~data_m, segment_out_o)
        `CHK("on_commons", 2'h3, {common_out_a_o, common_out_b_o})
        wb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, q)
        // with the clock enable low a shift clock edge is lost
        ce_i <= 1'b0;
        i_host_link.send_bit(1'b1);
        ce_i <= 1'b1;
        chk_regs();
        n = 4096 + ($random(seed) & 32'h3ff);
        repeat (n) begin
            clock_in_i <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            clock_in_i <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
        end
        repeat (8) @(posedge clk_sys_i);
        for (int k = 0; k < DIV_TAPS; k++)
            `CHK("div_tap", n[DIV_TAP_BIT[k]], div_tap_o[k])
        hi = 0;
        repeat (8000) begin
            @(posedge clk_sys_i);
            if (osc_out_o !== 1'b0) hi++;
        end
        `CHK("osc_off_highs", 0, hi)
        osc_enable_n_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (osc_out_o !== 1'b1 && n < 5000);
        `CHK("osc_running", 1'b1, osc_out_o)
        rst_b_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        `CHK("reset_outputs", 42'h0, {segment_out_o, common_out_a_o, common_out_b_o})
        rst_b_i <= 1'b1;
        shift_m = '0;
        data_m = '0;
        @(posedge clk_sys_i);
        chk_regs();
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl_reset", 32'h0, q)
        final_report();
    end
endmodule : static_lcd_segment_driver_tb
